// [bench/pwm_chk.sv]
// Assertions on the PWM channel ports.
`timescale 1ns/100ps
`include "pwm_defs.svh"
module pwm_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        read,
    input wire logic        write,
    input wire logic        waitrequest,
    input wire logic        sibling_output,
    input wire logic        pwm_output_pin,
    input wire logic        match_interrupt,
    input wire logic        irq,
    input wire logic [7:0]  address,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata
);
    logic       run_q, lvl_q, msk_q, wr_ok;
    logic [8:0] gap;
    assign wr_ok = write && !waitrequest;
    // Mode writes are tracked only while stopped, because a running channel ignores them.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {run_q, lvl_q, msk_q, gap} <= '0;
        end else begin
            if (wr_ok && address[7:2] == `IDX_CONTROL) run_q <= writedata[0];
            if (wr_ok && address[7:2] == `IDX_MODE && !run_q) lvl_q <= writedata[0];
            if (wr_ok && address[7:2] == `IDX_MASK) msk_q <= writedata[0];
            gap <= (match_interrupt || !run_q) ? 9'h0 : gap + 9'(gap != 9'h1ff);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("wait");
    a_irq_pulse: assert property (match_interrupt |=> !match_interrupt) else $error("pulse");
    a_irq_gap: assert property (match_interrupt |-> gap >= 9'd255) else $error("odd");
    a_wrap_idle: assert property (match_interrupt |-> pwm_output_pin == lvl_q)
        else $error("wrap");
    a_stop_idle: assert property (!run_q && !$past(run_q) && $stable(lvl_q)
        |-> pwm_output_pin == lvl_q) else $error("idle");
    a_stop_quiet: assert property (!run_q && !$past(run_q) |-> !match_interrupt)
        else $error("quiet");
    a_irq_mask: assert property (match_interrupt && msk_q |-> ##[0:1] irq) else $error("irq");
    a_irq_off: assert property (!msk_q && !$past(msk_q) |-> !irq) else $error("mask");
    c_irq: cover property (match_interrupt && msk_q);
    c_stop: cover property ($fell(run_q));
    c_read: cover property (read && !waitrequest);
endmodule : pwm_chk

bind timer_pwm_7bit_extra_pulse pwm_chk pwm_chk_inst (.*);

// [bench/pwm_load.sv]
// Load on the PWM pin that measures how many clocks each level lasts.
`timescale 1ns/100ps
module pwm_load (
    input  wire logic       clk,
    input  wire logic       pwm_output_pin,
    output logic      [9:0] last_len,
    output logic            changed
);
    logic       prev = 1'b0;
    logic [9:0] run  = 10'h0;
    // A passive load never drives the pin, so every edge reaches it unaltered.
    always @(posedge clk) begin
        prev     <= pwm_output_pin;
        changed  <= pwm_output_pin != prev;
        last_len <= (pwm_output_pin != prev) ? run : last_len;
        run      <= (pwm_output_pin != prev) ? 10'h1 : run + 10'h1;
    end
endmodule : pwm_load

// [bench/tb.sv]
// Random and corner tests of the PWM channel.
`timescale 1ns/100ps
`include "pwm_defs.svh"
module tb;
    logic        clk = 1'b0, reset, read, write, sibling_output;
    logic        waitrequest, pwm_output_pin, match_interrupt, irq, changed;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [9:0]  last_len;
    logic [6:0]  w, w2;
    int          bad_count = 0, n_checks = 0, k;

    always #5 clk = ~clk;
    timer_pwm_7bit_extra_pulse timer_pwm_7bit_extra_pulse_inst (.*);
    pwm_load pwm_load_inst (.*);

    function automatic logic [31:0] mode_val(input logic lvl, input logic dbl);
        return {24'h0, 1'b0, `MODE_PWM, 3'h7, dbl, lvl};
    endfunction : mode_val

    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic guard(input int i);
        if (i >= 600) begin
            bad_count++;
            test_done();
        end
    endtask : guard

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0 && ++i < 600);
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        guard(i);
    endtask : bus

    task automatic run_chk(input logic [31:0] exp, input logic on);
        int i = 0;
        do @(negedge clk); while (changed !== 1'b1 && ++i < 600);
        guard(i);
        if (on) chk("run", exp, 32'(last_len));
    endtask : run_chk

    initial begin
        {reset, read, write, sibling_output} = 4'h8;
        address = 8'h0;
        writedata = 32'h0;
        void'($urandom(62));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, 8'ha4, 32'h0);
        chk("duty", 32'hff, q);
        bus(1'b0, 8'hfc, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, 8'hb4, 32'h1);
        for (k = 0; k < 4; k++) begin
            w = 7'($urandom_range(120, 4));
            bus(1'b1, 8'ha8, mode_val(k[0], 1'b0));
            bus(1'b1, 8'ha4, {24'h0, w, k[1]});
            bus(1'b1, 8'hac, 32'h1);
            run_chk(0, 0);
            run_chk(128 - w, 1);
            run_chk(w + k[1], 1);
            run_chk(128 - w - k[1], 1);
            bus(1'b0, 8'hb0, 32'h0);
            chk("status", 32'h3, q);
            chk("irq", 1, irq);
            bus(1'b1, 8'hb0, 32'h1);
            repeat (2) @(negedge clk);
            chk("irq", 0, irq);
            bus(1'b1, 8'ha8, mode_val(!k[0], 1'b0));
            bus(1'b1, 8'hac, 32'h0);
            repeat (2) @(negedge clk);
            chk("level", k[0], pwm_output_pin);
        end
        w = 7'($urandom_range(120, 24));
        w2 = 7'($urandom_range(120, 4));
        bus(1'b1, 8'ha8, mode_val(1'b0, 1'b1));
        bus(1'b1, 8'ha4, {24'h0, w, 1'b0});
        bus(1'b1, 8'hac, 32'h1);
        bus(1'b1, 8'ha4, {24'h0, w2, 1'b0});
        bus(1'b0, 8'ha4, 32'h0);
        chk("read", {24'h0, w2, 1'b0}, q);
        run_chk(0, 0);
        run_chk(128 - w, 1);
        run_chk(w, 1);
        run_chk(128 - w, 1);
        run_chk(w2, 1);
        bus(1'b1, 8'hac, 32'h0);
        bus(1'b1, 8'ha8, {24'h0, 1'b0, `MODE_PWM, 3'h6, 2'h0});
        bus(1'b1, 8'hac, 32'h1);
        run_chk(0, 0);
        run_chk(2 * (128 - w2), 1);
        run_chk(2 * w2, 1);
        bus(1'b1, 8'hac, 32'h2);
        bus(1'b1, 8'ha8, mode_val(1'b0, 1'b0));
        bus(1'b1, 8'hac, 32'h3);
        repeat (200) @(negedge clk);
        chk("and", 0, pwm_output_pin);
        @(posedge clk);
        sibling_output <= 1'b1;
        run_chk(0, 0);
        chk("and", 1, pwm_output_pin);
        test_done();
    end
endmodule : tb

// [verilog/pwm_defs.svh]
// Register indices, field positions, reset values and counts of the PWM timer channel.
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

`define IDX_DUTY          6'h29
`define IDX_MODE          6'h2a
`define IDX_CONTROL       6'h2b
`define IDX_STATUS        6'h2c
`define IDX_MASK          6'h2d

`define DUTY_RESET        8'hff
`define DUTY_EXTRA_BIT    0
`define DUTY_WIDTH_MSB    7
`define DUTY_WIDTH_LSB    1

`define MODE_RESET        8'h00
`define MODE_LEVEL_BIT    0
`define MODE_BUFFER_BIT   1
`define MODE_CLOCK_LSB    2
`define MODE_CLOCK_MSB    4
`define MODE_SELECT_LSB   5
`define MODE_SELECT_MSB   6
`define MODE_EXTIN_BIT    7
`define MODE_PWM          2'h2

`define CTRL_RUN_BIT      0
`define CTRL_AND_BIT      1
`define CTRL_CASCADE_BIT  2

`define STAT_MATCH_BIT    0
`define STAT_RUNNING_BIT  1

`define CYCLE_LAST        7'h7f
`define PRESCALE_WIDTH    11

`endif

// [verilog/pwm_pkg.sv]
// Types shared by the PWM timer channel.
package pwm_pkg;

    typedef enum logic [1:0] {
        bus_idle = 2'b01,
        bus_ack  = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t  bus;
        logic        waitrequest;
        logic [31:0] readdata;
        logic [7:0]  duty_active;
        logic [7:0]  duty_buffer;
        logic [7:0]  mode;
        logic [2:0]  control;
        logic        match_status;
        logic        match_mask;
        logic [10:0] prescale;
        logic [6:0]  count;
        logic        even_cycle;
        logic        duty_reached;
        logic        pwm_output_pin;
        logic        match_interrupt;
        logic        irq;
    } state_t;

endpackage : pwm_pkg

// [verilog/timer_pwm_7bit_extra_pulse.sv]
// Seven-bit PWM timer channel with extra pulse, double buffer and Avalon-MM registers.
// Contract
// - Seven-bit duty width sets the first output change within a 128-count cycle.
// - Extra pulse enable delays every even cycle's change to duty width plus one.
// - Idle output level follows initial level select before start and after stop.
// - While stopped the pin carries the initial level select value.
// - Counter low bits equal to duty width toggle the output away from idle.
// - At count 128 the counter clears and the output returns to idle.
// - Match interrupt rises on even overflows only, never on odd ones.
// - While running with AND select set the pin carries both sibling outputs ANDed.
// - Setting run control starts counting on the selected source clock.
// - Clearing run control stops, clears the counter and restores idle level.
// - Buffer enable chooses double buffering of the duty register.
// - Buffered writes while running reach the active value at even overflow.
// - With buffering a duty read returns the last value written.
// - Writes while stopped update the active value and the buffer at once.
// - Unbuffered writes while running act at once; lower values wait for wrap.
// - Unbuffered write equal to the count matches immediately after the write.
// - Mode register writes are ignored while the timer runs.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`include "pwm_defs.svh"

module timer_pwm_7bit_extra_pulse (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        sibling_output,
    output logic             pwm_output_pin,
    output logic             match_interrupt,
    output logic             irq
);

    pwm_pkg::state_t state;
    pwm_pkg::state_t next_state;

    logic [5:0]  index;
    logic        accept;
    logic        write_now;
    logic        running;
    logic        tick;
    logic        overflow;
    logic        even_overflow;
    logic [7:0]  target;
    logic [10:0] prescale_mask;
    logic        level;
    logic        channel_level;
    logic [31:0] read_value;

    assign index = address[7:2];

    always_comb begin
        next_state = state;

        // Bus handshake: one wait cycle, then the request completes.
        accept    = (read | write) && (state.bus == pwm_pkg::bus_idle);
        write_now = write && (state.bus == pwm_pkg::bus_ack);
        unique case (state.bus)
            pwm_pkg::bus_idle: begin
                if (accept) begin
                    next_state.bus         = pwm_pkg::bus_ack;
                    next_state.waitrequest = 1'b0;
                end
            end
            pwm_pkg::bus_ack: begin
                next_state.bus         = pwm_pkg::bus_idle;
                next_state.waitrequest = 1'b1;
            end
            default: begin
                next_state.bus         = pwm_pkg::bus_idle;
                next_state.waitrequest = 1'b1;
            end
        endcase

        running = state.control[`CTRL_RUN_BIT];
        level   = state.mode[`MODE_LEVEL_BIT];

        // Source clock tick from a free-running prescaler.
        next_state.prescale = state.prescale + 11'h001;
        unique case (state.mode[`MODE_CLOCK_MSB:`MODE_CLOCK_LSB])
            3'h0:    prescale_mask = 11'h7ff;
            3'h1:    prescale_mask = 11'h3ff;
            3'h2:    prescale_mask = 11'h0ff;
            3'h3:    prescale_mask = 11'h03f;
            3'h4:    prescale_mask = 11'h00f;
            3'h5:    prescale_mask = 11'h003;
            3'h6:    prescale_mask = 11'h001;
            3'h7:    prescale_mask = 11'h000;
        endcase
        tick = running && ((state.prescale & prescale_mask) == 11'h000);

        overflow      = tick && (state.count == `CYCLE_LAST);
        even_overflow = overflow && state.even_cycle;

        target = {1'b0, state.duty_active[`DUTY_WIDTH_MSB:`DUTY_WIDTH_LSB]};
        if (state.duty_active[`DUTY_EXTRA_BIT] && state.even_cycle) begin
            target = target + 8'h01;
        end

        if (running) begin
            if (tick) begin
                next_state.count = state.count + 7'h01;
            end
            if (overflow) begin
                next_state.count        = 7'h00;
                next_state.duty_reached = 1'b0;
                next_state.even_cycle   = ~state.even_cycle;
            end else if (({1'b0, next_state.count} == target)
                         || ({1'b0, state.count} == target)) begin
                // match toggles output
                // The new count lets the pin move with the count; the old one catches a late write.
                next_state.duty_reached = 1'b1;
            end
        end else begin
            next_state.count        = 7'h00;
            next_state.duty_reached = 1'b0;
            next_state.even_cycle   = 1'b0;
        end

        if (even_overflow && state.mode[`MODE_BUFFER_BIT]) begin
            next_state.duty_active = state.duty_buffer;
        end

        next_state.match_interrupt = even_overflow;

        // Register writes take effect at the edge that completes the request.
        if (write_now) begin
            unique case (index)
                `IDX_DUTY: begin
                    // buffer always keeps the last write
                    next_state.duty_buffer = writedata[7:0];
                    // immediate update unless buffered and running
                    if (!running || !state.mode[`MODE_BUFFER_BIT]) begin
                        next_state.duty_active = writedata[7:0];
                    end
                end
                `IDX_MODE: begin
                    if (!running) begin
                        next_state.mode = writedata[7:0];
                    end
                end
                `IDX_CONTROL: begin
                    next_state.control = writedata[2:0];
                end
                `IDX_MASK: begin
                    next_state.match_mask = writedata[`STAT_MATCH_BIT];
                end
                default: begin
                end
            endcase
        end

        // Sticky status: a new event wins over a write-one clear.
        if (write_now && (index == `IDX_STATUS) && writedata[`STAT_MATCH_BIT]) begin
            next_state.match_status = 1'b0;
        end
        if (even_overflow) begin
            next_state.match_status = 1'b1;
        end
        next_state.irq = next_state.match_status & next_state.match_mask;

        // Read data is captured when the request is accepted.
        read_value = 32'h0000_0000;
        unique case (index)
            `IDX_DUTY:    read_value[7:0] = state.duty_buffer;
            `IDX_MODE:    read_value[7:0] = state.mode;
            `IDX_CONTROL: read_value[2:0] = state.control;
            `IDX_STATUS: begin
                read_value[`STAT_MATCH_BIT]   = state.match_status;
                read_value[`STAT_RUNNING_BIT] = running;
            end
            `IDX_MASK:    read_value[`STAT_MATCH_BIT] = state.match_mask;
            default:      read_value = 32'h0000_0000;
        endcase
        if (accept && read) begin
            next_state.readdata = read_value;
        end

        // The pin is registered from the next state, so it moves at the same edge as the state that causes it.
        if (next_state.control[`CTRL_RUN_BIT]) begin
            // active level between match and overflow
            channel_level = level ^ next_state.duty_reached;
            if (next_state.control[`CTRL_AND_BIT]) begin
                channel_level = channel_level & sibling_output;
            end
        end else begin
            channel_level = next_state.mode[`MODE_LEVEL_BIT];
        end
        next_state.pwm_output_pin = channel_level;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state              <= '0;
            state.bus          <= pwm_pkg::bus_idle;
            state.waitrequest  <= 1'b1;
            state.duty_active  <= `DUTY_RESET;
            state.duty_buffer  <= `DUTY_RESET;
            state.mode         <= `MODE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign readdata        = state.readdata;
    assign waitrequest     = state.waitrequest;
    assign pwm_output_pin  = state.pwm_output_pin;
    assign match_interrupt = state.match_interrupt;
    assign irq             = state.irq;

endmodule : timer_pwm_7bit_extra_pulse
